/* File: inc/service_dispatch_pkg.sv */
// Shared constants, types and priority function for the microcode service dispatch
package service_dispatch_pkg;
   localparam int CS_ADDR_W = 9;
   localparam int UINSTR_W = 16;
   localparam int NAF_W = 9;
   localparam int DAL_W = 16;
   localparam int GPO_W = 4;
   localparam int RANK_W = 5;
   localparam logic [CS_ADDR_W-1:0] SERVICE_ADDR = 9'h000;
   localparam logic [CS_ADDR_W-1:0] CS_ADDR_LAST = 9'h1ff;
   localparam logic [CS_ADDR_W-1:0] SVC_ENTRY_BASE = 9'h100;
   localparam int MACRO_ADDR_LO = 7;
   // Service word bit positions
   localparam int SVC_WAIT = 15;
   localparam int SVC_TBIT = 14;
   localparam int SVC_STK = 13;
   localparam int SVC_POWER_FAIL_FLAG = 7;
   localparam logic [DAL_W-1:0] SVC_ACTIVE_LOW = 16'h0018;
   localparam logic [RANK_W-1:0] RANK_FETCH = 5'h11;
   // Bit checked at each rank, highest first
   localparam int RANK_BIT [16] = '{0, 4, 3, 1, 2, 6, 14, 13, 7, 8, 12, 9, 10, 11, 5, 15};
   // Start-up word fields
   localparam int SU_BOOT_LO = 9;
   localparam int SU_FORCE = 8;
   localparam int SU_PWR_OK = 7;
   localparam int SU_HALT_JMP = 2;
   localparam int SU_PWRUP_JMP = 1;
   localparam int SU_DEBUG = 0;
   localparam logic [DAL_W-1:0] BOOT_FIXED = 16'hf600;
   localparam logic [DAL_W-1:0] HALT_TRAP_VEC = 16'h0008;
   localparam logic [DAL_W-1:0] PWRUP_VEC = 16'h0014;
   localparam logic [GPO_W-1:0] GPO_STARTUP = 4'ha;
   // Phase sub-state indices
   localparam logic [1:0] PBT_SAMPLE = 2'h1;
   localparam logic [1:0] PT_FIRST = 2'h0;

   typedef struct packed {
      logic [NAF_W-1:0] next_address_field;
      logic [UINSTR_W-1:0] uinstr;
   } cs_word_t;

   typedef struct packed {
      logic chip_reset;
      logic control_error;
      logic relocation_error;
      logic parity_error;
      logic bus_error;
      logic delayed_power_low;
   } force_pins_t;

   typedef enum logic [1:0] {
      ST_SERVICE = 2'b00,
      ST_RUN = 2'b01
   } seq_state_t;

   // Rank of the highest asserted request, fetch when none
   function automatic logic [RANK_W-1:0] svc_rank(input logic [DAL_W-1:0] w);
      logic [DAL_W-1:0] a;
      logic [RANK_W-1:0] r;
      a = w ^ SVC_ACTIVE_LOW;
      r = RANK_FETCH;
      for (int i = 15; i >= 0; i--)
      begin
         if (a[RANK_BIT[i]])
            r = RANK_W'(i + 1);
      end
      return r;
   endfunction
endpackage

/* File: verilog/control_store.sv */
// Microcode control store: logic-array quadrant plus three ROM quadrants
`timescale 1ns/10ps
module control_store
   import service_dispatch_pkg::*;
#(
   parameter int ADDR_W = CS_ADDR_W
)
(
   input wire logic clock,
   input wire logic ce,
   input wire logic load_en,
   input wire logic [ADDR_W-1:0] load_addr,
   input wire service_dispatch_pkg::cs_word_t load_word,
   input wire logic [ADDR_W-1:0] read_addr,
   output service_dispatch_pkg::cs_word_t read_word
);
   localparam int QUAD_DEPTH = 2 ** (ADDR_W - 2);
   localparam logic [ADDR_W-1:0] ROM_BASE = ADDR_W'(QUAD_DEPTH);

   // First quadrant held apart as the logic array, the rest as ROM
   cs_word_t pla_terms [QUAD_DEPTH];
   cs_word_t rom_words [3*QUAD_DEPTH];

   // Contents are loaded at bring-up; no image is built in
   always_ff @(posedge clock)
   begin
      if (ce && load_en)
      begin
         if (load_addr < ROM_BASE)
            pla_terms[load_addr[ADDR_W-3:0]] <= load_word;
         else
            rom_words[load_addr - ROM_BASE] <= load_word;
      end
   end

   // Registered read, one cycle after the address
   always_ff @(posedge clock)
   begin
      if (ce)
      begin
         if (read_addr < ROM_BASE)
            read_word <= pla_terms[read_addr[ADDR_W-3:0]];
         else
            read_word <= rom_words[read_addr - ROM_BASE];
      end
   end
endmodule

/* File: verilog/service_dispatch.sv */
// Control path: sequencing, service sampling, priority dispatch and start-up word
`timescale 1ns/10ps
module service_dispatch
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic phase_bar_time,
   input wire logic [1:0] phase_time_state,
   input wire logic relocation_cycle_active_n,
   input wire logic [service_dispatch_pkg::GPO_W-1:0] general_output_code,
   input wire logic halt_executing,
   input wire logic load_macro,
   input wire logic wait_set,
   input wire logic wait_clear,
   input wire logic trace_trap_bit,
   input wire logic stack_overflow_set,
   input wire logic stack_overflow_clear,
   input wire logic [service_dispatch_pkg::DAL_W-1:0] shared_data_address_lines,
   input wire service_dispatch_pkg::force_pins_t force_pins,
   input wire logic cs_load_en,
   input wire logic [service_dispatch_pkg::CS_ADDR_W-1:0] cs_load_addr,
   input wire service_dispatch_pkg::cs_word_t cs_load_word,
   output logic [service_dispatch_pkg::UINSTR_W-1:0] microword_bus,
   output logic [service_dispatch_pkg::CS_ADDR_W-1:0] microaddress,
   output logic [service_dispatch_pkg::DAL_W-1:0] decode_input_register,
   output logic [service_dispatch_pkg::RANK_W-1:0] service_rank,
   output logic [service_dispatch_pkg::DAL_W-1:0] startup_option_word,
   output logic [service_dispatch_pkg::DAL_W-1:0] boot_address,
   output logic powerup_via_vector,
   output logic halt_trap,
   output logic console_debug_mode,
   output logic power_ok
);
   import service_dispatch_pkg::*;

   logic [DAL_W-1:0] dal_meta_reg, dal_sync_reg;
   force_pins_t force_meta_reg, force_sync_reg;
   logic force_any;
   logic pbt_prev_reg;
   logic pbt_to_pt;
   logic load_svc;
   logic load_su;
   logic wait_flag_reg, stack_overflow_flag_reg;
   logic [DAL_W-1:0] svc_word;
   logic [DAL_W-1:0] dir_reg;
   logic [RANK_W-1:0] rank_reg;
   seq_state_t state_reg, state_next;
   logic [CS_ADDR_W-1:0] uaddr_reg, uaddr_next;
   logic [UINSTR_W-1:0] mir_reg, mwb_reg;
   cs_word_t cs_word;
   logic [DAL_W-1:0] su_reg, boot_reg;
   logic vec_reg, trap_reg, debug_reg, pok_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; first stage is read only by the second
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         dal_meta_reg <= '0;
         dal_sync_reg <= '0;
         force_meta_reg <= '0;
         force_sync_reg <= '0;
      end
      else if (ce)
      begin
         dal_meta_reg <= shared_data_address_lines;
         dal_sync_reg <= dal_meta_reg;
         force_meta_reg <= force_pins;
         force_sync_reg <= force_meta_reg;
      end
   end

   // Any error source forces the service state like a chip reset
   assign force_any = |force_sync_reg;
   assign pbt_to_pt = pbt_prev_reg && !phase_bar_time;
   // No sampling while the relocation unit owns the lines
   assign load_svc = phase_bar_time && phase_time_state == PBT_SAMPLE
                     && relocation_cycle_active_n;
   assign load_su = !phase_bar_time && phase_time_state != PT_FIRST
                    && (general_output_code == GPO_STARTUP || halt_executing);

   ////////////////////////////////////////////////////////////////////////////
   // Internal service flags; a set wins over a clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         wait_flag_reg <= 1'b0;
         stack_overflow_flag_reg <= 1'b0;
         pbt_prev_reg <= 1'b0;
      end
      else if (ce)
      begin
         pbt_prev_reg <= phase_bar_time;
         if (wait_set)
            wait_flag_reg <= 1'b1;
         else if (wait_clear)
            wait_flag_reg <= 1'b0;
         if (stack_overflow_set)
            stack_overflow_flag_reg <= 1'b1;
         else if (stack_overflow_clear)
            stack_overflow_flag_reg <= 1'b0;
      end
   end

   // Top three line bits are not trusted; internal flags take their place
   assign svc_word = {wait_flag_reg, trace_trap_bit, stack_overflow_flag_reg,
                      dal_sync_reg[SVC_STK-1:0]};

   ////////////////////////////////////////////////////////////////////////////
   // Decode input register and rank, captured at one instant
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         dir_reg <= '0;
         rank_reg <= RANK_FETCH;
      end
      else if (ce)
      begin
         if (load_svc)
         begin
            dir_reg <= svc_word;
            rank_reg <= svc_rank(svc_word);
         end
         else if (load_macro)
            dir_reg <= dal_sync_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next microaddress: service dispatch, macro decode or next-address field
   always_comb
   begin
      state_next = state_reg;
      uaddr_next = uaddr_reg;
      unique case (state_reg)
         ST_SERVICE:
         begin
            if (pbt_to_pt)
            begin
               uaddr_next = SVC_ENTRY_BASE + CS_ADDR_W'(rank_reg);
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (pbt_to_pt)
            begin
               if (load_macro)
                  uaddr_next = dir_reg[DAL_W-1 -: CS_ADDR_W];
               else
                  uaddr_next = cs_word.next_address_field;
               if (uaddr_next == SERVICE_ADDR)
                  state_next = ST_SERVICE;
            end
         end
         default:
         begin
            state_next = ST_SERVICE;
            uaddr_next = SERVICE_ADDR;
         end
      endcase
   end

   // Reset and error both land on microaddress 0 in the service state
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_reg <= ST_SERVICE;
         uaddr_reg <= SERVICE_ADDR;
      end
      else if (ce)
      begin
         if (force_any)
         begin
            state_reg <= ST_SERVICE;
            uaddr_reg <= SERVICE_ADDR;
         end
         else
         begin
            state_reg <= state_next;
            uaddr_reg <= uaddr_next;
         end
      end
   end

   control_store #(.ADDR_W(CS_ADDR_W)) u_store (
      .clock(clock),
      .ce(ce),
      .load_en(cs_load_en),
      .load_addr(cs_load_addr),
      .load_word(cs_load_word),
      .read_addr(uaddr_reg),
      .read_word(cs_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Microword bus: fetched word in phase bar time, latched control in phase time
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         mir_reg <= '0;
         mwb_reg <= '0;
      end
      else if (ce)
      begin
         if (pbt_to_pt)
            mir_reg <= cs_word.uinstr;
         mwb_reg <= phase_bar_time ? cs_word.uinstr : mir_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up word and the options decoded from it
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         su_reg <= '0;
         boot_reg <= BOOT_FIXED;
         vec_reg <= 1'b0;
         trap_reg <= 1'b0;
         debug_reg <= 1'b0;
         pok_reg <= 1'b0;
      end
      else if (ce)
      begin
         if (load_su)
            su_reg <= dal_sync_reg;
         // Only upper bits come from the word; low bits of the boot address are zero
         boot_reg <= su_reg[SU_FORCE] ? BOOT_FIXED
                     : {su_reg[DAL_W-1:SU_BOOT_LO], {SU_BOOT_LO{1'b0}}};
         vec_reg <= su_reg[SU_PWRUP_JMP];
         trap_reg <= halt_executing && !su_reg[SU_HALT_JMP]
                     && !dir_reg[SVC_POWER_FAIL_FLAG];
         debug_reg <= su_reg[SU_DEBUG];
         pok_reg <= su_reg[SU_PWR_OK];
      end
   end

   assign microword_bus = mwb_reg;
   assign microaddress = uaddr_reg;
   assign decode_input_register = dir_reg;
   assign service_rank = rank_reg;
   assign startup_option_word = su_reg;
   assign boot_address = boot_reg;
   assign powerup_via_vector = vec_reg;
   assign halt_trap = trap_reg;
   assign console_debug_mode = debug_reg;
   assign power_ok = pok_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_force_service;
      @(posedge clock) disable iff (rst)
      ce && force_any |=> uaddr_reg == SERVICE_ADDR && state_reg == ST_SERVICE;
   endproperty
   a_force_service: assert property (p_force_service)
      else $error("forced service did not reach microaddress 0");

   property p_error_pin_forces;
      @(posedge clock) disable iff (rst)
      ce && force_pins.parity_error ##1 ce ##1 ce |=> uaddr_reg == SERVICE_ADDR;
   endproperty
   a_error_pin_forces: assert property (p_error_pin_forces)
      else $error("error pin did not force service");

   property p_internal_bits;
      @(posedge clock) disable iff (rst)
      ce && load_svc |=> dir_reg[SVC_WAIT:SVC_STK]
         == $past({wait_flag_reg, trace_trap_bit, stack_overflow_flag_reg});
   endproperty
   a_internal_bits: assert property (p_internal_bits)
      else $error("service bits 15:13 not taken from internal flags");

   property p_rank_matches;
      @(posedge clock) disable iff (rst)
      ce && load_svc |=> rank_reg == svc_rank(dir_reg);
   endproperty
   a_rank_matches: assert property (p_rank_matches)
      else $error("rank differs from sampled service word");

   property p_idle_fetch;
      @(posedge clock) disable iff (rst)
      ce && load_svc && (svc_word ^ SVC_ACTIVE_LOW) == '0 |=> rank_reg == RANK_FETCH;
   endproperty
   a_idle_fetch: assert property (p_idle_fetch)
      else $error("no request did not yield instruction fetch");

   property p_reloc_hold;
      @(posedge clock) disable iff (rst)
      ce && !relocation_cycle_active_n && !load_macro |=> $stable(dir_reg);
   endproperty
   a_reloc_hold: assert property (p_reloc_hold)
      else $error("decode register loaded during relocation");

   property p_dispatch_entry;
      @(posedge clock) disable iff (rst)
      ce && state_reg == ST_SERVICE && pbt_to_pt && !force_any
         |=> uaddr_reg == SVC_ENTRY_BASE + CS_ADDR_W'($past(rank_reg));
   endproperty
   a_dispatch_entry: assert property (p_dispatch_entry)
      else $error("service dispatch went to wrong entry");

   property p_forced_boot;
      @(posedge clock) disable iff (rst)
      ce && su_reg[SU_FORCE] |=> boot_reg == BOOT_FIXED;
   endproperty
   a_forced_boot: assert property (p_forced_boot)
      else $error("boot address not forced");

   property p_halt_allowed;
      @(posedge clock) disable iff (rst)
      ce && su_reg[SU_HALT_JMP] |=> !trap_reg;
   endproperty
   a_halt_allowed: assert property (p_halt_allowed)
      else $error("halt trapped with jumper fitted");

   property p_vector_follows;
      @(posedge clock) disable iff (rst)
      ce |=> vec_reg == $past(su_reg[SU_PWRUP_JMP]);
   endproperty
   a_vector_follows: assert property (p_vector_follows)
      else $error("power-up vector choice does not follow jumper bit");

   property p_bus_in_pbt;
      @(posedge clock) disable iff (rst)
      ce && phase_bar_time |=> microword_bus == $past(cs_word.uinstr);
   endproperty
   a_bus_in_pbt: assert property (p_bus_in_pbt)
      else $error("microword bus not showing fetched word in phase bar time");
endmodule

/* File: dv/service_far_side.sv */
// Far-side model: service logic, relocation unit and start-up option logic
`timescale 1ns/10ps
module service_far_side
(
   input wire logic clock,
   input wire logic phase_bar_time,
   input wire logic [1:0] phase_time_state,
   input wire logic relocation_cycle_active_n,
   input wire logic [service_dispatch_pkg::GPO_W-1:0] general_output_code,
   input wire logic halt_executing,
   input wire logic [service_dispatch_pkg::DAL_W-1:0] service_word,
   input wire logic [service_dispatch_pkg::DAL_W-1:0] relocated_address,
   input wire logic [service_dispatch_pkg::DAL_W-1:0] startup_word,
   output logic [service_dispatch_pkg::DAL_W-1:0] shared_data_address_lines
);
   import service_dispatch_pkg::*;
   logic service_info_drive_n;
   logic relocation_drive;
   logic startup_word_drive_n;

   ////////////////////////////////////////////////////////////
   // Drive enables from the phase timing
   assign service_info_drive_n = !(phase_bar_time && phase_time_state == PBT_SAMPLE
      && relocation_cycle_active_n);
   assign relocation_drive = phase_bar_time && !relocation_cycle_active_n;
   assign startup_word_drive_n = !(!phase_bar_time && phase_time_state != PT_FIRST
      && (general_output_code == GPO_STARTUP || halt_executing));

   // Released lines toggle so stale data never passes for fresh data
   initial shared_data_address_lines = 16'h5a5a;
   always @(posedge clock)
   begin
      if (!service_info_drive_n)
         shared_data_address_lines <= service_word;
      else if (relocation_drive)
         shared_data_address_lines <= relocated_address;
      else if (!startup_word_drive_n)
         shared_data_address_lines <= startup_word;
      else
         shared_data_address_lines <= ~shared_data_address_lines;
   end
endmodule

/* File: dv/test_microcode_service_dispatch.sv */
// Self-checking bench for the microcode service dispatch
`timescale 1ns/10ps
module test_microcode_service_dispatch;
   import service_dispatch_pkg::*;
   // Bit tested at each rank, highest first
   localparam int RB [16] = '{0, 4, 3, 1, 2, 6, 14, 13, 7, 8, 12, 9, 10, 11, 5, 15};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic phase_bar = 1'b0;
   logic [1:0] phase_state = 2'h0;
   logic reloc_n = 1'b1;
   logic [GPO_W-1:0] out_code = 4'h0;
   logic halt = 1'b0;
   logic w_set = 1'b0;
   logic w_clr = 1'b0;
   logic tbit = 1'b0;
   logic s_set = 1'b0;
   logic s_clr = 1'b0;
   logic lm = 1'b0;
   force_pins_t fp = 6'h00;
   logic ld_en = 1'b0;
   logic [CS_ADDR_W-1:0] ld_addr = 9'h000;
   cs_word_t ld_word = 25'h0000000;
   logic [DAL_W-1:0] svc = 16'h0018;
   logic [DAL_W-1:0] su = 16'h0000;
   logic [DAL_W-1:0] lines;
   logic [UINSTR_W-1:0] microword_bus;
   logic [CS_ADDR_W-1:0] microaddress;
   logic [DAL_W-1:0] decode_input_register;
   logic [RANK_W-1:0] service_rank;
   logic [DAL_W-1:0] startup_option_word;
   logic [DAL_W-1:0] boot_address;
   logic powerup_via_vector;
   logic halt_trap;
   logic console_debug_mode;
   logic power_ok;
   int num_errors = 0;
   int n_tests = 0;

   ////////////////////////////////////////////////////////////
   // Clock and the two ends
   initial forever #2 clock = ~clock;

   service_far_side far
   (
      .clock(clock),
      .phase_bar_time(phase_bar),
      .phase_time_state(phase_state),
      .relocation_cycle_active_n(reloc_n),
      .general_output_code(out_code),
      .halt_executing(halt),
      .service_word(svc),
      .relocated_address(16'h1234),
      .startup_word(su),
      .shared_data_address_lines(lines)
   );

   service_dispatch dut
   (
      .clock(clock),
      .rst(rst),
      .ce(1'b1),
      .phase_bar_time(phase_bar),
      .phase_time_state(phase_state),
      .relocation_cycle_active_n(reloc_n),
      .general_output_code(out_code),
      .halt_executing(halt),
      .load_macro(lm),
      .wait_set(w_set),
      .wait_clear(w_clr),
      .trace_trap_bit(tbit),
      .stack_overflow_set(s_set),
      .stack_overflow_clear(s_clr),
      .shared_data_address_lines(lines),
      .force_pins(fp),
      .cs_load_en(ld_en),
      .cs_load_addr(ld_addr),
      .cs_load_word(ld_word),
      .microword_bus(microword_bus),
      .microaddress(microaddress),
      .decode_input_register(decode_input_register),
      .service_rank(service_rank),
      .startup_option_word(startup_option_word),
      .boot_address(boot_address),
      .powerup_via_vector(powerup_via_vector),
      .halt_trap(halt_trap),
      .console_debug_mode(console_debug_mode),
      .power_ok(power_ok)
   );

   ////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Internal flags set first, then external bits held through the synchroniser
   task automatic sample(input logic [15:0] a);
      w_set = a[15];
      w_clr = !a[15];
      s_set = a[13];
      s_clr = !a[13];
      tbit = a[14];
      svc = {~a[15:13], a[12:0] ^ 13'h0018}; // Bits 4 and 3 low-true
      tick(1);
      {w_set, w_clr, s_set, s_clr} = 4'h0;
      phase_bar = 1'b1;
      phase_state = PBT_SAMPLE;
      tick(5);
   endtask

   // Entry words: next field zero returns to service
   task automatic load_store();
      for (int i = 1; i <= 17; i++)
      begin
         ld_en = 1'b1;
         ld_addr = 9'(9'h100 + i);
         ld_word = '{next_address_field: 9'h000, uinstr: 16'hc000 | 16'(9'h100 + i)};
         tick(1);
      end
      // Service entry word keeps the bus defined at microaddress 0
      ld_addr = SERVICE_ADDR;
      ld_word = '{next_address_field: 9'h000, uinstr: 16'hc000};
      tick(1);
      // Macro target in the logic-array quadrant, chained to the fetch entry
      ld_addr = 9'h024;
      ld_word = '{next_address_field: 9'h111, uinstr: 16'h5024};
      tick(1);
      ld_en = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_reset();
      check("ua", 16'(microaddress), 16'h0000); // Service entry
      check("rank", 16'(service_rank), 16'h0011); // Fetch rank
      check("dir", decode_input_register, 16'h0000); // Cleared
      check("su", startup_option_word, 16'h0000); // Cleared
      check("boot", boot_address, 16'h0000); // Cleared word, bits 15:9 zero
   endtask

   // Each rank asserted together with every lower rank
   task automatic test_priority();
      logic [15:0] a;
      for (int r = 1; r <= 17; r++)
      begin
         a = 16'h0000;
         for (int k = r - 1; k < 16; k++)
            a[RB[k]] = 1'b1;
         sample(a);
         check("dir", decode_input_register, {a[15:13], a[12:0] ^ 13'h0018}); // Load
         check("rank", 16'(service_rank), 16'(r)); // Winner
         phase_bar = 1'b0;
         phase_state = 2'h0;
         tick(1);
         check("entry", 16'(microaddress), 16'(9'h100 + r)); // Dispatch
         phase_bar = 1'b1;
         phase_state = 2'h2;
         tick(4);
         check("ubus", microword_bus, 16'hc000 | 16'(9'h100 + r)); // Entry word
         phase_bar = 1'b0;
         phase_state = 2'h0;
         tick(1);
         check("next", 16'(microaddress), 16'h0000); // Next field
      end
   endtask

   // Relocation blocks the service load
   task automatic test_reloc();
      reloc_n = 1'b0;
      sample(16'h0001);
      check("dir", decode_input_register, 16'h0018); // Kept
      check("rank", 16'(service_rank), 16'h0011); // Kept
      reloc_n = 1'b1;
      phase_bar = 1'b0;
      tick(1);
   endtask

   task automatic test_startup(input logic [15:0] v, input logic [3:0] g, input logic h,
      input logic [15:0] e);
      su = v;
      out_code = g;
      halt = h;
      phase_state = 2'h1;
      tick(2);
      phase_state = 2'h3;
      tick(3);
      phase_state = 2'h0;
      out_code = 4'h0;
      tick(3);
      check("su", startup_option_word, e); // Capture
      check("boot", boot_address, e[8] ? 16'hf600 : {e[15:9], 9'h000}); // Boot
      check("vector", 16'(powerup_via_vector), 16'(e[1])); // Jumper
      check("debug", 16'(console_debug_mode), 16'(e[0])); // Debug
      check("pwr", 16'(power_ok), 16'(e[7])); // Power good
      check("trap", 16'(halt_trap), 16'(h & !e[2])); // Halt trap
      halt = 1'b0;
   endtask

   // Macro word from the relocated lines picks the microaddress, then its next field chains on
   task automatic test_macro();
      reloc_n = 1'b0;
      phase_bar = 1'b1;
      phase_state = 2'h2;
      lm = 1'b1;
      tick(4);
      check("macro", decode_input_register, 16'h1234); // Loaded from lines
      reloc_n = 1'b1;
      phase_bar = 1'b0;
      tick(1);
      check("maddr", 16'(microaddress), 16'h0024); // Bits 15:7 of the word
      lm = 1'b0;
      phase_bar = 1'b1;
      tick(4);
      check("ubus", microword_bus, 16'h5024); // Logic-array quadrant word
      phase_bar = 1'b0;
      phase_state = 2'h0;
      tick(1);
      check("chain", 16'(microaddress), 16'h0111); // Nonzero next field
   endtask

   // Every forcing pin drops a running sequence to address zero
   task automatic test_force();
      int k;
      for (int i = 0; i < 6; i++)
      begin
         if (microaddress === 9'h000)
         begin
            phase_bar = 1'b1;
            tick(2);
            phase_bar = 1'b0;
            tick(1);
         end
         check("run", 16'(microaddress), 16'h0111); // Fetch entry
         fp = force_pins_t'(6'h20 >> i);
         k = 0;
         while (microaddress !== 9'h000 && k < 8)
         begin
            tick(1);
            k++;
         end
         check("forced", 16'(microaddress), 16'h0000); // Forced
         fp = force_pins_t'(6'h00);
         tick(4);
      end
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence and watchdog
   initial
   begin
      tick(2);
      check("boot", boot_address, 16'hf600); // Reset value
      rst = 1'b0;
      tick(1);
      test_reset();
      load_store();
      test_priority();
      test_reloc();
      test_startup(16'h8186, 4'ha, 1'b0, 16'h8186);
      test_startup(16'h4a01, 4'h0, 1'b1, 16'h4a01);
      test_startup(16'hffff, 4'h3, 1'b0, 16'h4a01);
      test_macro();
      test_force();
      end_of_test();
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      num_errors++;
      end_of_test();
   end
endmodule
